// ---- verilog/trt_map.svh ----
// register indices, field positions, reset values and timing figures
`ifndef TRT_MAP_SVH
`define TRT_MAP_SVH
`define TRT_IDX_PA_RAMP 10'h052
`define TRT_IDX_PLL     10'h053
`define TRT_IDX_BOOST   10'h054
`define TRT_IDX_CTRL    10'h060
`define TRT_IDX_STAT    10'h061
`define TRT_IDX_DTB     10'h062
`define TRT_RST_PA_RAMP 8'h00
`define TRT_RST_PLL     8'h52
`define TRT_RST_BOOST   8'h54
`define TRT_RST_DTB     6'h00
`define TRT_F_TXMOD     6:4
`define TRT_F_LDORAMP   3:2
`define TRT_F_TXRAMP    1:0
`define TRT_F_PLLTS     7:3
`define TRT_F_POST_CAL_SETTLE_TIME     2:0
`define TRT_F_PRETH     5:2
`define TRT_C_TXGO      0
`define TRT_C_TXSTOP    1
`define TRT_C_COLD      2
`define TRT_C_RETUNE    3
`define TRT_CLK_MHZ     25
`define TRT_MODSTEP_US  4
`define TRT_RAMPSTEP_US 5
`define TRT_PLLSTEP_US  10
`define TRT_PRE_BITS    4
`define TRT_DTB_RXPH    6'h31
`define TRT_DTB_RXERR   6'h34
`endif

// ---- verilog/trt_pkg.sv ----
// types shared by the transmit ramp and pll settle timing block
package trt_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_LDO, TX_PA, TX_MOD, TX_DOWN} trt_tx_e;
   typedef enum logic [1:0] {PLL_IDLE, PLL_T0, PLL_TS, PLL_LOCK} trt_pll_e;
   // receive-path signals offered to the test bus
   typedef struct packed {
      logic header_bad;
      logic crc_bad;
      logic sync_seen;
      logic packet_hunting;
      logic preamble_ok;
      logic rx_packet_engine_on;
   } trt_rx_s;
   typedef logic [15:0] trt_cyc_t;
endpackage : trt_pkg

// ---- verilog/trt_timer.sv ----
// one-shot cycle timer: done pulses exactly len cycles after start, or one cycle after for a zero len
`timescale 1ns/1ns
module trt_timer
   import trt_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst_b,
   input  wire logic     start,
   input  wire trt_cyc_t len,
   output logic          done
);
   trt_cyc_t cnt_ff;
   logic     done_ff;

   // a zero length still takes one cycle so no interval comes out short
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_ff <= 16'h0000;
      end else if (start) begin
         cnt_ff <= (len == 16'h0000) ? 16'h0001 : len;
      end else if (cnt_ff != 16'h0000) begin
         cnt_ff <= cnt_ff - 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= (cnt_ff == 16'h0001) && !start;
      end
   end

   assign done = done_ff;
endmodule : trt_timer

// ---- verilog/trt_top.sv ----
// transmit ramp, pll settle and preamble window timing with test bus and apb registers
// Behaviour
// RULE_01: modulation waits programmed delay after amp on
// RULE_02: same delay applied on amplifier ramp down
// RULE_03: regulator ramp 5 to 20 us by code
// RULE_04: amplifier ramp-up 5 to 20 us by code
// RULE_05: retune waits soft settle time, 10 us units
// RULE_06: pll settle register resets to 0x52
// RULE_07: post-calibration settle 0 to 70 us
// RULE_08: post-calibration settle resets to 20 us
// RULE_09: cold start waits both settle times summed
// RULE_10: preamble window is threshold times four bits
// RULE_11: code 52 shows sync, checksum, header errors
// RULE_12: code 49 shows engine, preamble, hunting
// RULE_13: test bus code picks three pin signals
// RULE_14: counters never end before programmed time
// RULE_15: software programs timings before starting sequences
`timescale 1ns/1ns
`include "trt_map.svh"
module trt_top
   import trt_pkg::*;
#(
   parameter int CYC_PER_US = `TRT_CLK_MHZ
)
(
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        BIT_TICK,
   input  wire logic        PRE_START,
   input  wire trt_rx_s     RX_SIG,
   output logic             LDO_EN,
   output logic             PA_EN,
   output logic             PA_RAMP,
   output logic             MOD_EN,
   output logic             PLL_SETTLED,
   output logic             PRE_WIN_OPEN,
   output logic [2:0]       GPIO_TB
);
   localparam int MOD_STEP  = `TRT_MODSTEP_US * CYC_PER_US;
   localparam int RAMP_STEP = `TRT_RAMPSTEP_US * CYC_PER_US;
   localparam int PLL_STEP  = `TRT_PLLSTEP_US * CYC_PER_US;

   logic [7:0]  pa_ramp_reg_ff;
   logic [7:0]  pll_reg_ff;
   logic [7:0]  boost_reg_ff;
   logic [5:0]  dtb_sel_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [31:0] nxt_rdata;
   logic        nxt_err;
   logic        wr_go;
   logic        tx_go;
   logic        tx_stop;
   logic        cold_go;
   logic        retune_go;
   trt_tx_e     tx_st_ff;
   trt_tx_e     nxt_tx;
   trt_pll_e    pll_st_ff;
   trt_pll_e    nxt_pll;
   logic        ldo_en_ff;
   logic        pa_en_ff;
   logic        pa_ramp_ff;
   logic        mod_en_ff;
   logic        settled_ff;
   logic        cold_ff;
   logic        tx_tmr_go;
   trt_cyc_t    tx_tmr_len;
   logic        tx_tmr_done;
   logic        ramp_tmr_done;
   logic        pll_tmr_go;
   trt_cyc_t    pll_tmr_len;
   logic        pll_tmr_done;
   trt_cyc_t    mod_cyc;
   trt_cyc_t    ldo_cyc;
   trt_cyc_t    ramp_cyc;
   trt_cyc_t    ts_cyc;
   trt_cyc_t    t0_cyc;
   logic [5:0]  pre_cnt_ff;
   logic [5:0]  pre_len;
   logic        win_open_ff;
   logic [2:0]  gpio_ff;
   trt_cyc_t    pa_age_ff;
   trt_cyc_t    pll_age_ff;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave

   // one wait state so read data leaves from a flop
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end else begin
         pready_ff  <= PSEL && PENABLE && !pready_ff;
         pslverr_ff <= PSEL && PENABLE && !pready_ff && nxt_err;
         prdata_ff  <= (PSEL && PENABLE && !PWRITE) ? nxt_rdata : 32'h00000000;
      end
   end

   assign PREADY  = pready_ff;
   assign PSLVERR = pslverr_ff;
   assign PRDATA  = prdata_ff;
   assign wr_go   = PSEL && PENABLE && PWRITE && pready_ff && !pslverr_ff;

   // decode: index times four, misaligned or unknown words answer with an error
   always_comb begin
      nxt_rdata = 32'h00000000;
      nxt_err   = 1'b0;
      if (PADDR[1:0] != 2'h0) begin
         nxt_err = 1'b1;
      end else begin
         case (PADDR[11:2])
            `TRT_IDX_PA_RAMP: nxt_rdata = {24'h000000, pa_ramp_reg_ff};
            `TRT_IDX_PLL:     nxt_rdata = {24'h000000, pll_reg_ff};
            `TRT_IDX_BOOST:   nxt_rdata = {24'h000000, boost_reg_ff};
            `TRT_IDX_CTRL:    nxt_rdata = 32'h00000000;
            `TRT_IDX_STAT:    nxt_rdata = {24'h000000, 1'b0, win_open_ff, settled_ff,
                                           pll_st_ff != PLL_IDLE && pll_st_ff != PLL_LOCK,
                                           mod_en_ff, pa_en_ff, ldo_en_ff,
                                           tx_st_ff != TX_IDLE};
            `TRT_IDX_DTB:     nxt_rdata = {26'h0000000, dtb_sel_ff};
            default:          nxt_err   = 1'b1;
         endcase
      end
   end

   // timing registers; reserved bits are kept as plain storage
   // RULE_06: pll register reset
   // RULE_08: post-calibration default 20 us
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         pa_ramp_reg_ff <= `TRT_RST_PA_RAMP;
         pll_reg_ff     <= `TRT_RST_PLL;
         boost_reg_ff   <= `TRT_RST_BOOST;
         dtb_sel_ff     <= `TRT_RST_DTB;
      end else if (wr_go) begin
         case (PADDR[11:2])
            `TRT_IDX_PA_RAMP: pa_ramp_reg_ff <= PWDATA[7:0];
            `TRT_IDX_PLL:     pll_reg_ff     <= PWDATA[7:0];
            `TRT_IDX_BOOST:   boost_reg_ff   <= PWDATA[7:0];
            `TRT_IDX_DTB:     dtb_sel_ff     <= PWDATA[5:0];
            default:          ;
         endcase
      end
   end

   // command bits act once per write and never store
   assign tx_go     = wr_go && PADDR[11:2] == `TRT_IDX_CTRL && PWDATA[`TRT_C_TXGO];
   assign tx_stop   = wr_go && PADDR[11:2] == `TRT_IDX_CTRL && PWDATA[`TRT_C_TXSTOP];
   assign cold_go   = wr_go && PADDR[11:2] == `TRT_IDX_CTRL && PWDATA[`TRT_C_COLD];
   assign retune_go = wr_go && PADDR[11:2] == `TRT_IDX_CTRL && PWDATA[`TRT_C_RETUNE];

   ////////////////////////////////////////////////////////////////////////////
   // field codes to cycle counts

   // RULE_01: 4 us modulation steps
   assign mod_cyc  = trt_cyc_t'(32'(pa_ramp_reg_ff[`TRT_F_TXMOD]) * MOD_STEP);
   // RULE_03: code plus one, 5 us each
   assign ldo_cyc  = trt_cyc_t'((32'(pa_ramp_reg_ff[`TRT_F_LDORAMP]) + 1) * RAMP_STEP);
   // RULE_04: code plus one, 5 us each
   assign ramp_cyc = trt_cyc_t'((32'(pa_ramp_reg_ff[`TRT_F_TXRAMP]) + 1) * RAMP_STEP);
   // RULE_05: 10 us soft settle units
   assign ts_cyc   = trt_cyc_t'(32'(pll_reg_ff[`TRT_F_PLLTS]) * PLL_STEP);
   // RULE_07: 10 us initial settle steps
   assign t0_cyc   = trt_cyc_t'(32'(pll_reg_ff[`TRT_F_POST_CAL_SETTLE_TIME]) * PLL_STEP);

   ////////////////////////////////////////////////////////////////////////////
   // transmit sequencer

   // RULE_14: all intervals counted on mclk
   trt_timer u_tx_tmr (
      .clk   (MCLK),
      .rst_b (RST_B),
      .start (tx_tmr_go),
      .len   (tx_tmr_len),
      .done  (tx_tmr_done)
   );

   trt_timer u_ramp_tmr (
      .clk   (MCLK),
      .rst_b (RST_B),
      .start (tx_st_ff == TX_LDO && tx_tmr_done),
      .len   (ramp_cyc),
      .done  (ramp_tmr_done)
   );

   // regulator first, then amplifier with modulation held back, then ramp down
   always_comb begin
      nxt_tx     = tx_st_ff;
      tx_tmr_go  = 1'b0;
      tx_tmr_len = mod_cyc;
      case (tx_st_ff)
         TX_IDLE: begin
            if (tx_go) begin
               nxt_tx     = TX_LDO;
               tx_tmr_go  = 1'b1;
               tx_tmr_len = ldo_cyc;
            end
         end
         TX_LDO: begin
            if (tx_stop) begin
               nxt_tx = TX_IDLE;
            end else if (tx_tmr_done) begin
               // RULE_01: delay counts from amp on
               nxt_tx    = TX_PA;
               tx_tmr_go = 1'b1;
            end
         end
         TX_PA: begin
            if (tx_stop) begin
               nxt_tx    = TX_DOWN;
               tx_tmr_go = 1'b1;
            end else if (tx_tmr_done) begin
               nxt_tx = TX_MOD;
            end
         end
         TX_MOD: begin
            if (tx_stop) begin
               // RULE_02: same delay on ramp down
               nxt_tx    = TX_DOWN;
               tx_tmr_go = 1'b1;
            end
         end
         TX_DOWN: begin
            if (tx_tmr_done) begin
               nxt_tx = TX_IDLE;
            end
         end
         default: nxt_tx = TX_IDLE;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         tx_st_ff <= TX_IDLE;
      end else begin
         tx_st_ff <= nxt_tx;
      end
   end

   // enables follow the next state so they line up with it
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         ldo_en_ff <= 1'b0;
         pa_en_ff  <= 1'b0;
         mod_en_ff <= 1'b0;
      end else begin
         ldo_en_ff <= nxt_tx != TX_IDLE;
         pa_en_ff  <= nxt_tx == TX_PA || nxt_tx == TX_MOD || nxt_tx == TX_DOWN;
         mod_en_ff <= nxt_tx == TX_MOD;
      end
   end

   // RULE_04: amplifier ramp window
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         pa_ramp_ff <= 1'b0;
      end else if (tx_st_ff == TX_LDO && tx_tmr_done && !tx_stop) begin
         pa_ramp_ff <= 1'b1;
      end else if (ramp_tmr_done || !pa_en_ff) begin
         pa_ramp_ff <= 1'b0;
      end
   end

   assign LDO_EN  = ldo_en_ff;
   assign PA_EN   = pa_en_ff;
   assign PA_RAMP = pa_ramp_ff;
   assign MOD_EN  = mod_en_ff;

   ////////////////////////////////////////////////////////////////////////////
   // pll settle sequencer

   trt_timer u_pll_tmr (
      .clk   (MCLK),
      .rst_b (RST_B),
      .start (pll_tmr_go),
      .len   (pll_tmr_len),
      .done  (pll_tmr_done)
   );

   // requests while settling are dropped; the running wait is not disturbed
   always_comb begin
      nxt_pll     = pll_st_ff;
      pll_tmr_go  = 1'b0;
      pll_tmr_len = ts_cyc;
      case (pll_st_ff)
         PLL_IDLE, PLL_LOCK: begin
            if (cold_go) begin
               nxt_pll     = PLL_T0;
               pll_tmr_go  = 1'b1;
               pll_tmr_len = t0_cyc;
            end else if (retune_go) begin
               // RULE_05: retune waits soft time only
               nxt_pll    = PLL_TS;
               pll_tmr_go = 1'b1;
            end
         end
         PLL_T0: begin
            if (pll_tmr_done) begin
               // RULE_09: soft time follows initial time
               nxt_pll    = PLL_TS;
               pll_tmr_go = 1'b1;
            end
         end
         PLL_TS: begin
            if (pll_tmr_done) begin
               nxt_pll = PLL_LOCK;
            end
         end
         default: nxt_pll = PLL_IDLE;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         pll_st_ff  <= PLL_IDLE;
         settled_ff <= 1'b0;
         cold_ff    <= 1'b0;
      end else begin
         pll_st_ff  <= nxt_pll;
         settled_ff <= nxt_pll == PLL_LOCK;
         if (pll_tmr_go && pll_st_ff != PLL_T0) begin
            cold_ff <= nxt_pll == PLL_T0;
         end
      end
   end

   assign PLL_SETTLED = settled_ff;

   ////////////////////////////////////////////////////////////////////////////
   // invalid preamble window

   // RULE_10: threshold times four bit ticks
   assign pre_len = {boost_reg_ff[`TRT_F_PRETH], 2'b00};

   // a zero threshold never opens the window
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         pre_cnt_ff  <= 6'h00;
         win_open_ff <= 1'b0;
      end else if (PRE_START) begin
         pre_cnt_ff  <= 6'h00;
         win_open_ff <= pre_len != 6'h00;
      end else if (win_open_ff && BIT_TICK) begin
         pre_cnt_ff <= pre_cnt_ff + 6'h01;
         if (pre_cnt_ff + 6'h01 == pre_len) begin
            win_open_ff <= 1'b0;
         end
      end
   end

   assign PRE_WIN_OPEN = win_open_ff;

   ////////////////////////////////////////////////////////////////////////////
   // digital test bus

   // RULE_13: code selects pin signals
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         gpio_ff <= 3'h0;
      end else begin
         case (dtb_sel_ff)
            // RULE_12: engine, preamble, hunting
            `TRT_DTB_RXPH:  gpio_ff <= {RX_SIG.packet_hunting, RX_SIG.preamble_ok, RX_SIG.rx_packet_engine_on};
            // RULE_11: sync, checksum, header
            `TRT_DTB_RXERR: gpio_ff <= {RX_SIG.header_bad, RX_SIG.crc_bad, RX_SIG.sync_seen};
            default:        gpio_ff <= 3'h0;
         endcase
      end
   end

   assign GPIO_TB = gpio_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // cycle ages seen only by the checks below
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         pa_age_ff  <= 16'h0000;
         pll_age_ff <= 16'h0000;
      end else begin
         pa_age_ff  <= pa_en_ff ? pa_age_ff + 16'h0001 : 16'h0000;
         pll_age_ff <= (pll_st_ff == PLL_T0 || pll_st_ff == PLL_TS) ? pll_age_ff + 16'h0001 : 16'h0000;
      end
   end

   a_mod_delay_exact: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_01
      $rose(mod_en_ff) |-> pa_age_ff == ((mod_cyc == 16'h0000) ? 16'h0001 : mod_cyc) + 16'h0001)
      else $error("modulation started off its programmed delay");

   a_mod_ramp_down: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_02
      $fell(mod_en_ff) |-> pa_en_ff ##[1:1000] !pa_en_ff)
      else $error("amplifier did not hold through ramp down");

   a_ldo_before_pa: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_03
      $rose(pa_en_ff) |-> $past(ldo_en_ff) && ldo_en_ff)
      else $error("amplifier on before regulator ramp");

   a_pa_ramp_start: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_04
      $rose(pa_en_ff) && $past(tx_st_ff) == TX_LDO |-> pa_ramp_ff ##1 pa_ramp_ff)
      else $error("amplifier ramp window missing");

   a_retune_settle: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_05
      $rose(settled_ff) && !cold_ff |-> pll_age_ff > ts_cyc)
      else $error("retune settled too early");

   a_pll_reg_reset: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_06
      $past(!RST_B) |-> pll_reg_ff == 8'h52)
      else $error("pll settle register reset value wrong");

   a_t0_reset_20us: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_08
      $past(!RST_B) |-> 32'(pll_reg_ff[`TRT_F_POST_CAL_SETTLE_TIME]) * PLL_STEP == 20 * CYC_PER_US)
      else $error("initial settle default is not 20 us");

   a_cold_settle_sum: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_09
      $rose(settled_ff) && cold_ff |-> pll_age_ff > ts_cyc + t0_cyc)
      else $error("cold start settled before both times");

   a_pre_window_len: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_10
      $fell(win_open_ff) && !$past(PRE_START) |-> pre_cnt_ff == pre_len && $past(BIT_TICK))
      else $error("preamble window closed at wrong bit count");

   a_tb_code_52: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_11
      dtb_sel_ff == `TRT_DTB_RXERR |=>
         GPIO_TB == $past({RX_SIG.header_bad, RX_SIG.crc_bad, RX_SIG.sync_seen}))
      else $error("test bus code 52 routes wrong signals");

   a_tb_code_49: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_12
      dtb_sel_ff == `TRT_DTB_RXPH |=>
         GPIO_TB == $past({RX_SIG.packet_hunting, RX_SIG.preamble_ok, RX_SIG.rx_packet_engine_on}))
      else $error("test bus code 49 routes wrong signals");

   // the stop edge itself restarts the timer while modulation is still on, so tie to state instead
   a_mod_needs_pa: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_14
      mod_en_ff |-> pa_en_ff && ldo_en_ff && tx_st_ff == TX_MOD)
      else $error("modulation without amplifier");
endmodule : trt_top

// ---- test/tb_top.sv ----
// self-checking bench for the transmit ramp and pll settle timing block
`timescale 1ns/1ns
`include "trt_map.svh"
module tb_top
   import trt_pkg::*;
;
   // one cycle per microsecond keeps every timed interval short
   localparam int          CPU    = 1;
   localparam logic [11:0] A_RAMP = {`TRT_IDX_PA_RAMP, 2'b00};
   localparam logic [11:0] A_PLL  = {`TRT_IDX_PLL, 2'b00};
   localparam logic [11:0] A_BST  = {`TRT_IDX_BOOST, 2'b00};
   localparam logic [11:0] A_CTRL = {`TRT_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_STAT = {`TRT_IDX_STAT, 2'b00};
   localparam logic [11:0] A_DTB  = {`TRT_IDX_DTB, 2'b00};
   localparam logic [11:0] A_BAD  = 12'h200;

   logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, bit_tick, pre_start;
   logic        ldo_en, pa_en, pa_ramp, mod_en, pll_settled, pre_win_open;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0]  gpio_tb;
   logic [5:0]  obs, prev;
   trt_rx_s     rx_sig;
   int          mismatches, n_checks, cyc, dc, dr, dr2, dc2;
   int          rise_t[6], fall_t[6];

   // observed levels: 0 regulator, 1 amp, 2 ramp, 3 modulation, 4 settled, 5 window
   assign obs = {pre_win_open, pll_settled, mod_en, pa_ramp, pa_en, ldo_en};

   trt_top #(.CYC_PER_US(CPU)) DUT (
      .MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .BIT_TICK(bit_tick), .PRE_START(pre_start), .RX_SIG(rx_sig), .LDO_EN(ldo_en),
      .PA_EN(pa_en), .PA_RAMP(pa_ramp), .MOD_EN(mod_en), .PLL_SETTLED(pll_settled),
      .PRE_WIN_OPEN(pre_win_open), .GPIO_TB(gpio_tb)
   );

   // free-running 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // stamps every edge of the outputs; stamps avoid racing parallel timers
   always @(posedge mclk) begin
      #1;
      cyc = cyc + 1;
      for (int i = 0; i < 6; i++) begin
         if (obs[i] === 1'b1 && prev[i] !== 1'b1)
            rise_t[i] = cyc;
         if (obs[i] === 1'b0 && prev[i] === 1'b1)
            fall_t[i] = cyc;
      end
      prev = obs;
      if (cyc > 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (mismatches == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // one apb transfer; request held until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 50, 1'b1, "apb ready");
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, r, e);
      chk({31'h0, e}, 32'h0, "write error");
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic eexp, input string what);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, what);
      chk({31'h0, e}, {31'h0, eexp}, what);
   endtask : rdc

   task automatic wait_bit(input int i, input logic lvl);
      int n;
      n = 0;
      while (obs[i] !== lvl && n < 3000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(n < 3000, 1'b1, "level wait");
   endtask : wait_bit

   ////////////////////////////////////////////////////////////////////////////////
   // transmit sequence with code set k
   task automatic tx_run(input int k);
      int l, m, r, e;
      l = (k % 4 + 1) * 5 * CPU;
      r = ((k + 1) % 4 + 1) * 5 * CPU;
      m = (k == 0) ? 1 : k * 4 * CPU;
      wr(A_RAMP, {1'b0, 3'(k), 2'(k % 4), 2'((k + 1) % 4)});
      wr(A_CTRL, 8'h01);
      e = cyc + 1;
      wait_bit(3, 1'b1);
      repeat (r + 2) @(posedge mclk);
      chk(rise_t[0], e, "regulator on");
      chk(rise_t[1] - rise_t[0], l + 1, "regulator ramp");
      chk(rise_t[2], rise_t[1], "ramp start");
      chk(fall_t[2] - rise_t[2], r + 1, "amp ramp");
      chk(rise_t[3] - rise_t[1], m + 1, "mod delay");
      rdc(A_STAT, 32'h0f, 1'b0, "status busy");
      // a second start while busy must leave the sequence alone
      wr(A_CTRL, 8'h01);
      rdc(A_STAT, 32'h0f, 1'b0, "start ignored");
      wr(A_CTRL, 8'h02);
      e = cyc + 1;
      wait_bit(1, 1'b0);
      @(posedge mclk);
      #2;
      chk(fall_t[3], e, "mod off");
      chk(fall_t[1] - fall_t[3], m + 1, "ramp down delay");
      chk(fall_t[0], fall_t[1], "regulator off");
   endtask : tx_run

   // settle request, returns cycles to settled
   task automatic pll_run(input logic [7:0] v, input logic [7:0] c, output int d);
      int e, n;
      wr(A_PLL, v);
      wr(A_CTRL, c);
      e = cyc + 1;
      n = 0;
      while (!(rise_t[4] > e) && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk(n < 3000, 1'b1, "settle wait");
      d = rise_t[4] - e;
   endtask : pll_run

   task automatic tick();
      @(posedge mclk);
      bit_tick <= 1'b1;
      @(posedge mclk);
      bit_tick <= 1'b0;
      @(posedge mclk);
      #1;
   endtask : tick

   // test bus selection and pin order
   task automatic tbus(input logic [5:0] sel, input logic [5:0] p, input logic [2:0] exp);
      wr(A_DTB, {2'b00, sel});
      @(posedge mclk);
      rx_sig <= p;
      repeat (2) @(posedge mclk);
      #1;
      chk({29'h0, gpio_tb}, {29'h0, exp}, "test bus");
   endtask : tbus

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] r;
      logic        e;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      bit_tick = 1'b0;
      pre_start = 1'b0;
      rx_sig = '0;
      rst_b = 1'b0;
      mismatches = 0;
      n_checks = 0;
      cyc = 0;
      prev = 6'h00;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      #1;
      chk({26'h0, obs}, 32'h0, "outputs idle");
      rdc(A_RAMP, 32'h00, 1'b0, "ramp reset");
      rdc(A_PLL, 32'h52, 1'b0, "pll reset");
      rdc(A_BST, 32'h54, 1'b0, "boost reset");
      rdc(A_DTB, 32'h00, 1'b0, "bus sel reset");
      rdc(A_BAD, 32'h00, 1'b1, "unmapped read");
      rdc(A_RAMP + 12'h001, 32'h00, 1'b1, "misaligned read");
      apb(1'b1, A_BAD, 32'h0000_00ff, r, e);
      chk({31'h0, e}, 32'h1, "unmapped write");
      apb(1'b1, A_RAMP, 32'hffff_ffff, r, e);
      rdc(A_RAMP, 32'hff, 1'b0, "ramp rw");
      rdc(A_CTRL, 32'h00, 1'b0, "control reads zero");
      for (int k = 0; k < 8; k++)
         tx_run(k);
      pll_run({5'h02, 3'h3}, 8'h04, dc);
      pll_run({5'h02, 3'h3}, 8'h08, dr);
      pll_run({5'h05, 3'h3}, 8'h08, dr2);
      pll_run({5'h02, 3'h7}, 8'h04, dc2);
      rdc(A_STAT, 32'h20, 1'b0, "settled status");
      chk(dc - dr, 30 * CPU + 1, "cold adds initial settle");
      chk(dr2 - dr, 30 * CPU, "soft settle step");
      chk(dc2 - dc, 40 * CPU, "initial settle step");
      chk(dr >= 20 * CPU, 1'b1, "settle not short");
      // threshold two gives an eight bit window
      wr(A_BST, 8'h08);
      @(posedge mclk);
      pre_start <= 1'b1;
      @(posedge mclk);
      pre_start <= 1'b0;
      repeat (7) tick();
      chk({31'h0, pre_win_open}, 32'h1, "window open");
      rdc(A_STAT, 32'h60, 1'b0, "window status");
      tick();
      chk({31'h0, pre_win_open}, 32'h0, "window closed");
      for (int p = 0; p < 64; p += 7) begin
         tbus(6'h31, 6'(p), 3'(p));
         tbus(6'h34, 6'(p), 3'(p >> 3));
         tbus(6'h32, 6'(p), 3'h0);
      end
      end_of_test();
   end
endmodule : tb_top
